/* File: verif/mdsp_sva.sv */
// Concurrent checks on the serial link between host and device
`default_nettype none
module mdsp_sva (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic frame_sync_in
);
  logic        sck_q;
  logic [4:0]  cnt_q;
  logic        wr_frame_q;
  logic [15:0] fs_cnt_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) sck_q <= 1'b0;
    else sck_q <= serial_clock;
  end

  // Raw pin rises, not the device's filtered view
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) cnt_q <= 5'h00;
    else if (!chip_select) cnt_q <= 5'h00;
    else if (serial_clock && !sck_q) cnt_q <= cnt_q + 5'h01;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) wr_frame_q <= 1'b0;
    else if (!chip_select) wr_frame_q <= 1'b0;
    else if (serial_clock && !sck_q && cnt_q == 5'h06) wr_frame_q <= !serial_data_in;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) fs_cnt_q <= 16'h0000;
    else if (!frame_sync_in) fs_cnt_q <= 16'h0000;
    else if (fs_cnt_q != 16'hffff) fs_cnt_q <= fs_cnt_q + 16'h0001;
  end

  sequence s_sck_high;
    serial_clock [*8];
  endsequence
  sequence s_cs_gap;
    (!chip_select) [*8];
  endsequence

  oe_off_a: assert property ((!chip_select) [*8] |-> !serial_data_out_oe)
    else $error("serial output enabled while deselected");
  oe_on_a: assert property (chip_select [*8] |-> serial_data_out_oe)
    else $error("serial output not driven while selected");
  head_zero_a: assert property (chip_select && cnt_q < 5'h07 |-> !serial_data_out)
    else $error("serial output not zero before read data");
  write_zero_a: assert property (chip_select && wr_frame_q |-> !serial_data_out)
    else $error("serial output not zero in write frame");
  frame_len_a: assert property ($fell(chip_select) |-> cnt_q == 5'd24)
    else $error("frame length not 24 clock rises");
  cs_gap_a: assert property ($fell(chip_select) |-> s_cs_gap)
    else $error("chip select gap too short");
  sck_idle_a: assert property ($rose(chip_select) |-> !serial_clock)
    else $error("serial clock high at frame start");
  sck_high_a: assert property ($rose(serial_clock) |-> s_sck_high ##1 !serial_clock)
    else $error("serial clock high phase wrong");
  sin_hold_a: assert property (chip_select && $rose(serial_clock) |-> ($stable(serial_data_in)) [*8])
    else $error("serial input moved while clock high");
  sync_width_a: assert property ($fell(frame_sync_in) |-> fs_cnt_q >= 16'd800)
    else $error("frame sync pulse too narrow");
  sync_cs_a: assert property ($changed(frame_sync_in) |-> (!$rose(chip_select)) [*4])
    else $error("chip select too soon after frame sync edge");
endmodule
`default_nettype wire

/* File: verif/mdsp_test.sv */
// Self-checking bench: host and device ends joined, plus a device driven by hand
`include "mdsp_regs.svh"
`default_nettype none
module mdsp_test
  import mdsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, reset_n, req, req_read, sync_req, req_ready, rd_valid, sync_ready;
  logic [5:0]  req_addr;
  logic [15:0] req_wdata, rd_data, got, wv;
  logic        sync_edge_select, test_enable_a, test_enable_b, dc_drive_enable, dc_drive_input_a, dc_drive_input_b;
  logic        frame_sync_tick, test_pulse_out, b_en, b_a, b_b;
  logic [4:0]  test_signal_select;
  logic [15:0] start_delay_pwm_cfg, phase_corr_excite_delay, peak_pulse_width, step_count_motion_ctrl, step_period;
  logic [23:0] rw;
  int          failures, n_checks, i, n_ticks;
  logic [5:0]  offs [8] = '{`MDSP_OFF_START_PWM, `MDSP_OFF_PHASE_DLY, `MDSP_OFF_PEAK_PW, `MDSP_OFF_STEP_CTRL,
                            `MDSP_OFF_STEP_PER, `MDSP_OFF_TEST_SEL, `MDSP_OFF_DC_CTRL, `MDSP_OFF_SYNC_TEST};
  logic [15:0] msks [8] = '{`MDSP_MASK_START_PWM, `MDSP_MASK_PHASE_DLY, `MDSP_MASK_PEAK_PW, `MDSP_MASK_STEP_CTRL,
                            `MDSP_MASK_STEP_PER, `MDSP_MASK_TEST_SEL, `MDSP_MASK_DC_CTRL, `MDSP_MASK_SYNC_TEST};

  mdsp_if link_if ();
  mdsp_if bad_if ();
  mdsp_dev u_mdsp_dev (.clk_sys, .reset_n, .link(link_if), .sync_edge_select, .test_enable_a, .test_enable_b,
    .test_signal_select, .dc_drive_enable, .dc_drive_input_a, .dc_drive_input_b, .start_delay_pwm_cfg,
    .phase_corr_excite_delay, .peak_pulse_width, .step_count_motion_ctrl, .step_period, .frame_sync_tick,
    .test_pulse_out);
  mdsp_dev u_mdsp_dev_2 (.clk_sys, .reset_n, .link(bad_if), .sync_edge_select(), .test_enable_a(),
    .test_enable_b(), .test_signal_select(), .dc_drive_enable(b_en), .dc_drive_input_a(b_a),
    .dc_drive_input_b(b_b), .start_delay_pwm_cfg(), .phase_corr_excite_delay(), .peak_pulse_width(),
    .step_count_motion_ctrl(), .step_period(), .frame_sync_tick(), .test_pulse_out());
  mdsp_host u_mdsp_host (.clk_sys, .reset_n, .link(link_if), .req, .req_read, .req_addr, .req_wdata,
    .req_ready, .rd_data, .rd_valid, .sync_req, .sync_ready);
  mdsp_sva u_mdsp_sva (.clk_sys, .reset_n, .chip_select(link_if.chip_select),
    .serial_clock(link_if.serial_clock), .serial_data_in(link_if.serial_data_in),
    .serial_data_out(link_if.serial_data_out), .serial_data_out_oe(link_if.serial_data_out_oe),
    .frame_sync_in(link_if.frame_sync_in));

  // The system clock doubles as the reference clock that writes rely on
  always #50 clk_sys = ~clk_sys;

  // Sync ticks are single-cycle pulses, so count them as they pass
  always @(posedge clk_sys) begin
    if (frame_sync_tick === 1'b1) n_ticks++;
  end

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: word got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: bit got %b expected %b", $time, g, e);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bail;
    failures++;
    $display("wrong value at %0t: handshake timed out", $time);
    conclude();
  endtask

  // One host frame; held until taken, then wait for the port to be free again
  task automatic host_op(input logic rd, input logic [5:0] a, input logic [15:0] d);
    int k;
    got = 'x;
    req <= 1'b1;
    req_read <= rd;
    req_addr <= a;
    req_wdata <= d;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (!req_ready && k < 2000);
    if (k >= 2000) bail();
    req <= 1'b0;
    k = 0;
    do begin @(posedge clk_sys); k++; if (rd_valid) got = rd_data; end while (!req_ready && k < 2000);
    if (k >= 2000) bail();
  endtask

  task automatic sync_pulse;
    int k;
    sync_req <= 1'b1;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (!sync_ready && k < 2000);
    sync_req <= 1'b0;
    if (k >= 2000) bail();
  endtask

  // Hand-driven frame of n bits at 800 ns per clock; output captured before each rise
  task automatic bb(input int n, input logic [23:0] w);
    rw = '0;
    bad_if.chip_select <= 1'b1;
    repeat (8) @(posedge clk_sys);
    for (int j = 0; j < n; j++) begin
      bad_if.serial_data_in <= w[j];
      repeat (4) @(posedge clk_sys);
      rw[j] = bad_if.serial_data_out_line;
      bad_if.serial_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bad_if.serial_clock <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    bad_if.chip_select <= 1'b0;
    bad_if.serial_data_in <= ~w[n-1];
    repeat (16) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    {req, req_read, sync_req, req_addr, req_wdata} = '0;
    {bad_if.chip_select, bad_if.serial_clock, bad_if.serial_data_in, bad_if.frame_sync_in} = '0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    for (i = 0; i < 8; i++) begin
      host_op(1'b1, offs[i], 16'h0000);
      chk_word(got, `MDSP_RESET_VALUE);
    end
    $display("test reset values done");
    // Polarity bit kept clear here so the sync edge stays rising
    for (i = 0; i < 8; i++) begin
      wv = (offs[i] == `MDSP_OFF_SYNC_TEST) ? 16'hfdff : 16'hffff;
      host_op(1'b0, offs[i], wv);
    end
    host_op(1'b0, 6'h3f, 16'hffff);
    chk_word(step_period, 16'h0000);
    chk_bit(dc_drive_enable & dc_drive_input_a & dc_drive_input_b, 1'b1);
    chk_word({test_enable_a, test_enable_b, sync_edge_select, test_signal_select}, 16'h00df);
    for (i = 0; i < 8; i++) begin
      wv = (offs[i] == `MDSP_OFF_SYNC_TEST) ? 16'hfdff : 16'hffff;
      host_op(1'b1, offs[i], 16'h0000);
      chk_word(got, wv & msks[i]);
    end
    host_op(1'b1, 6'h3f, 16'h0000);
    chk_word(got, 16'h0000);
    $display("test register access done");
    sync_pulse();
    repeat (10) @(posedge clk_sys);
    chk_word(step_period, 16'hffff);
    chk_word(start_delay_pwm_cfg, `MDSP_MASK_START_PWM);
    chk_word(step_count_motion_ctrl, `MDSP_MASK_STEP_CTRL);
    chk_word(16'(n_ticks), 16'h0001);
    repeat (800) @(posedge clk_sys);
    host_op(1'b0, `MDSP_OFF_SYNC_TEST, 16'h0200);
    chk_bit(sync_edge_select, 1'b1);
    host_op(1'b0, `MDSP_OFF_STEP_PER, 16'h1234);
    sync_pulse();
    repeat (400) @(posedge clk_sys);
    chk_word(step_period, 16'hffff);
    chk_bit(test_pulse_out, 1'b0);
    repeat (420) @(posedge clk_sys);
    chk_word(step_period, 16'h1234);
    chk_bit(test_pulse_out, 1'b1);
    // Rising edge, polarity flip, then falling edge
    chk_word(16'(n_ticks), 16'h0003);
    $display("test frame sync loading done");
    bb(24, {16'ha5c3, 1'b1, 1'b0, `MDSP_OFF_STEP_PER});
    bb(24, {16'h0000, 1'b0, 1'b1, `MDSP_OFF_STEP_PER});
    chk_word(rw[23:8], 16'ha5c3);
    chk_word({8'h00, rw[7:0]}, 16'h0000);
    chk_bit(bad_if.serial_data_out_oe, 1'b0);
    bb(24, {16'h0006, 2'b00, `MDSP_OFF_DC_CTRL});
    chk_word({13'h0000, b_en, b_a, b_b}, 16'h0006);
    bb(23, {16'h0001, 2'b00, `MDSP_OFF_DC_CTRL});
    chk_word({13'h0000, b_en, b_a, b_b}, 16'h0006);
    bb(24, {16'h0001, 2'b00, `MDSP_OFF_DC_CTRL});
    chk_word({13'h0000, b_en, b_a, b_b}, 16'h0001);
    $display("test wire frames done");
    conclude();
  end
endmodule
`default_nettype wire

/* File: verilog/mdsp_dev.sv */
// Device end: serial register port, register file and frame-sync loading
//
// Functional notes
// - Frame spans chip select high period
// - A transaction is exactly 24 bit periods
// - Sample input on serial clock rising edges
// - Read bits change on serial clock rise
// - Output off when deselected, else driven, zero outside read data
// - Chip select low resets serial control
// - Host keeps chip select low between frames
// - Host clocks steadily during selected frames
// - Address, control, data; all LSB first
// - Bit 6 selects read; bit 7 ignored
// - Host supplies reference clock for writes
// - DC bridge controls follow quickly
// - Frame sync pulse at least 80 us
// - Chip select 400 ns after sync edge; a request waiting as the pulse ends raises it on the edge that drops sync
// - Transfer ends 5 us before delay end
// - Reset pin clears every register
// - Sync edge select picks rising/falling
// - Motor settings load once per sync; a polarity bit write that raises the adjusted sync also loads them
`include "mdsp_regs.svh"
`default_nettype none
module mdsp_dev
  import mdsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  mdsp_if.dev              link,
  output logic             sync_edge_select,
  output logic             test_enable_a,
  output logic             test_enable_b,
  output logic [4:0]       test_signal_select,
  output logic             dc_drive_enable,
  output logic             dc_drive_input_a,
  output logic             dc_drive_input_b,
  output logic [15:0]      start_delay_pwm_cfg,
  output logic [15:0]      phase_corr_excite_delay,
  output logic [15:0]      peak_pulse_width,
  output logic [15:0]      step_count_motion_ctrl,
  output logic [15:0]      step_period,
  output logic             frame_sync_tick,
  output logic             test_pulse_out
);

  // Pin synchronisers: cs, sck, sin, frame sync
  logic [3:0] pin_in;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] filt_q;

  assign pin_in = {link.chip_select, link.serial_clock, link.serial_data_in, link.frame_sync_in};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          s1_q[g]   <= 1'b0;
          s2_q[g]   <= 1'b0;
          s3_q[g]   <= 1'b0;
          filt_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_in[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            filt_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  logic cs_f;
  logic sck_f;
  logic sin_f;
  logic fs_f;
  assign cs_f  = filt_q[3];
  assign sck_f = filt_q[2];
  assign sin_f = filt_q[1];
  assign fs_f  = filt_q[0];

  // Register file decode
  function automatic logic [3:0] mdsp_decode(input logic [5:0] addr);
    case (addr)
      `MDSP_OFF_SYNC_TEST: mdsp_decode = 4'h8;
      `MDSP_OFF_START_PWM: mdsp_decode = 4'h9;
      `MDSP_OFF_TEST_SEL:  mdsp_decode = 4'ha;
      `MDSP_OFF_PHASE_DLY: mdsp_decode = 4'hb;
      `MDSP_OFF_PEAK_PW:   mdsp_decode = 4'hc;
      `MDSP_OFF_STEP_CTRL: mdsp_decode = 4'hd;
      `MDSP_OFF_STEP_PER:  mdsp_decode = 4'he;
      `MDSP_OFF_DC_CTRL:   mdsp_decode = 4'hf;
      default:             mdsp_decode = 4'h0;
    endcase
  endfunction

  function automatic logic [15:0] mdsp_mask(input logic [2:0] idx);
    case (idx)
      3'd0:    mdsp_mask = `MDSP_MASK_SYNC_TEST;
      3'd1:    mdsp_mask = `MDSP_MASK_START_PWM;
      3'd2:    mdsp_mask = `MDSP_MASK_TEST_SEL;
      3'd3:    mdsp_mask = `MDSP_MASK_PHASE_DLY;
      3'd4:    mdsp_mask = `MDSP_MASK_PEAK_PW;
      3'd5:    mdsp_mask = `MDSP_MASK_STEP_CTRL;
      3'd6:    mdsp_mask = `MDSP_MASK_STEP_PER;
      default: mdsp_mask = `MDSP_MASK_DC_CTRL;
    endcase
  endfunction

  logic [15:0] regs_q [8];

  // Serial shifter
  logic        sck_prev_q;
  logic        sck_rise;
  logic [4:0]  bit_cnt_q;
  logic [23:0] shift_q;
  logic [15:0] rd_q;
  logic        reading_q;
  logic        wr_en_q;
  logic [5:0]  wr_addr_q;
  logic [15:0] wr_data_q;
  logic [3:0]  rd_dec;
  logic [3:0]  wr_dec;

  assign sck_rise = sck_f & ~sck_prev_q;
  // Bit 7 is being sampled: address sits in shift_q[22:17]
  assign rd_dec   = mdsp_decode(shift_q[22:17]);
  assign wr_dec   = mdsp_decode(wr_addr_q);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_f;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q <= 5'd0;
      shift_q   <= 24'h000000;
      rd_q      <= 16'h0000;
      reading_q <= 1'b0;
    end else if (!cs_f) begin
      bit_cnt_q <= 5'd0;
      shift_q   <= 24'h000000;
      rd_q      <= 16'h0000;
      reading_q <= 1'b0;
    end else if (sck_rise && bit_cnt_q < `MDSP_FRAME_BITS) begin
      shift_q   <= {sin_f, shift_q[23:1]};
      bit_cnt_q <= bit_cnt_q + 5'd1;
      if (bit_cnt_q == `MDSP_CTRL_BIT) begin
        // Bit 6 is the direction, bit 7 (just sampled) is dropped
        reading_q <= shift_q[23];
        rd_q      <= rd_dec[3] ? regs_q[rd_dec[2:0]] : 16'h0000;
      end else if (bit_cnt_q > `MDSP_CTRL_BIT) begin
        rd_q <= {1'b0, rd_q[15:1]};
      end
    end
  end

  // Commit only on the 24th rising edge; cut frames never get here
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_en_q   <= 1'b0;
      wr_addr_q <= 6'h00;
      wr_data_q <= 16'h0000;
    end else begin
      wr_en_q <= cs_f && sck_rise && bit_cnt_q == `MDSP_LAST_BIT && !shift_q[7];
      if (cs_f && sck_rise && bit_cnt_q == `MDSP_LAST_BIT) begin
        wr_addr_q <= shift_q[6:1];
        wr_data_q <= {sin_f, shift_q[23:9]};
      end
    end
  end

  // Output register; enable follows the filtered chip select
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      link.serial_data_out    <= 1'b0;
      link.serial_data_out_oe <= 1'b0;
    end else begin
      link.serial_data_out    <= cs_f & reading_q & rd_q[0];
      link.serial_data_out_oe <= cs_f;
    end
  end

  // Registers: masked writes, unmapped addresses ignored
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= `MDSP_RESET_VALUE;
      end
    end else if (wr_en_q && wr_dec[3]) begin
      regs_q[wr_dec[2:0]] <= wr_data_q & mdsp_mask(wr_dec[2:0]);
    end
  end

  // Frame sync edge detect on the selected polarity
  logic fs_pol;
  logic fs_prev_q;
  logic fs_tick;
  assign fs_pol  = fs_f ^ regs_q[0][`MDSP_BIT_SYNC_EDGE];
  assign fs_tick = fs_pol & ~fs_prev_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fs_prev_q       <= 1'b0;
      frame_sync_tick <= 1'b0;
      test_pulse_out  <= 1'b0;
    end else begin
      fs_prev_q       <= fs_pol;
      frame_sync_tick <= fs_tick;
      // Test output mirrors the polarity-adjusted sync when enabled
      test_pulse_out  <= regs_q[2][`MDSP_BIT_TEST_B] & fs_pol;
    end
  end

  // Motor settings move to the working copy on a sync edge, or when a polarity bit write raises the adjusted sync
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_delay_pwm_cfg     <= `MDSP_RESET_VALUE;
      phase_corr_excite_delay <= `MDSP_RESET_VALUE;
      peak_pulse_width        <= `MDSP_RESET_VALUE;
      step_count_motion_ctrl  <= `MDSP_RESET_VALUE;
      step_period             <= `MDSP_RESET_VALUE;
    end else if (fs_tick) begin
      start_delay_pwm_cfg     <= regs_q[1];
      phase_corr_excite_delay <= regs_q[3];
      peak_pulse_width        <= regs_q[4];
      step_count_motion_ctrl  <= regs_q[5];
      step_period             <= regs_q[6];
    end
  end

  // Immediate registers drive their outputs straight from the flops
  assign sync_edge_select   = regs_q[0][`MDSP_BIT_SYNC_EDGE];
  assign test_enable_a      = regs_q[0][`MDSP_BIT_TEST_A];
  assign test_enable_b      = regs_q[2][`MDSP_BIT_TEST_B];
  assign test_signal_select = regs_q[2][4:0];
  assign dc_drive_enable    = regs_q[7][`MDSP_BIT_DC_EN];
  assign dc_drive_input_a   = regs_q[7][`MDSP_BIT_DC_A];
  assign dc_drive_input_b   = regs_q[7][`MDSP_BIT_DC_B];

endmodule
`default_nettype wire

/* File: verilog/mdsp_host.sv */
// Host end: serial master with frame-sync pulse generator
`include "mdsp_regs.svh"
`default_nettype none
module mdsp_host
  import mdsp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  mdsp_if.host             link,
  input  wire logic        req,
  input  wire logic        req_read,
  input  wire logic [5:0]  req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             req_ready,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  input  wire logic        sync_req,
  output logic             sync_ready
);

  // Read-back pin: three flops, change taken when last two agree
  logic sd1_q;
  logic sd2_q;
  logic sd3_q;
  logic sdo_f;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sd1_q <= 1'b0;
      sd2_q <= 1'b0;
      sd3_q <= 1'b0;
      sdo_f <= 1'b0;
    end else begin
      sd1_q <= link.serial_data_out_line;
      sd2_q <= sd1_q;
      sd3_q <= sd2_q;
      if (sd2_q == sd3_q) begin
        sdo_f <= sd3_q;
      end
    end
  end

  // Frame sync pulse and chip select hold-off after each of its edges
  logic [9:0] fs_cnt_q;
  logic [2:0] hold_q;
  assign sync_ready = (fs_cnt_q == 10'd0) && !link.chip_select;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fs_cnt_q           <= 10'd0;
      link.frame_sync_in <= 1'b0;
      hold_q             <= 3'd0;
    end else begin
      if (sync_req && sync_ready) begin
        fs_cnt_q           <= 10'(`MDSP_FS_WIDTH_CYC);
        link.frame_sync_in <= 1'b1;
        hold_q             <= 3'(`MDSP_CS_WAIT_CYC);
      end else if (fs_cnt_q != 10'd0) begin
        fs_cnt_q <= fs_cnt_q - 10'd1;
        if (fs_cnt_q == 10'd1) begin
          link.frame_sync_in <= 1'b0;
          hold_q             <= 3'(`MDSP_CS_WAIT_CYC);
        end else if (hold_q != 3'd0) begin
          hold_q <= hold_q - 3'd1;
        end
      end else if (hold_q != 3'd0) begin
        hold_q <= hold_q - 3'd1;
      end
    end
  end

  // Serial master
  mdsp_host_state_t state_q;
  logic [3:0]       tim_q;
  logic [4:0]       bit_q;
  logic [23:0]      frame_q;
  logic             rd_op_q;
  logic             tim_end;
  assign tim_end   = tim_q == (`MDSP_SCK_HALF_CYC - 4'd1);
  // No new frame right after a sync edge, except one taken on the very edge that drops sync
  assign req_ready = state_q == MDSP_H_IDLE && hold_q == 3'd0 && !(sync_req && sync_ready);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q             <= MDSP_H_IDLE;
      tim_q               <= 4'd0;
      bit_q               <= 5'd0;
      frame_q             <= 24'h000000;
      rd_op_q             <= 1'b0;
      link.chip_select    <= 1'b0;
      link.serial_clock   <= 1'b0;
      link.serial_data_in <= 1'b0;
      rd_data             <= 16'h0000;
      rd_valid            <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      tim_q    <= tim_end ? 4'd0 : tim_q + 4'd1;
      case (state_q)
        MDSP_H_IDLE: begin
          tim_q <= 4'd0;
          if (req && req_ready) begin
            // Unused control bit sent as zero
            frame_q          <= {req_wdata, 1'b0, req_read, req_addr};
            rd_op_q          <= req_read;
            link.chip_select <= 1'b1;
            bit_q            <= 5'd0;
            state_q          <= MDSP_H_SETUP;
          end
        end
        MDSP_H_SETUP: begin
          if (tim_end) begin
            link.serial_data_in <= frame_q[0];
            state_q             <= MDSP_H_LOW;
          end
        end
        MDSP_H_LOW: begin
          if (tim_end) begin
            // Sample late in the low phase, after the device has moved
            if (bit_q > `MDSP_CTRL_BIT) begin
              rd_data <= {sdo_f, rd_data[15:1]};
            end
            link.serial_clock <= 1'b1;
            state_q           <= MDSP_H_HIGH;
          end
        end
        MDSP_H_HIGH: begin
          if (tim_end) begin
            link.serial_clock <= 1'b0;
            frame_q           <= {1'b0, frame_q[23:1]};
            link.serial_data_in <= frame_q[1];
            if (bit_q == `MDSP_LAST_BIT) begin
              state_q <= MDSP_H_END;
            end else begin
              bit_q   <= bit_q + 5'd1;
              state_q <= MDSP_H_LOW;
            end
          end
        end
        MDSP_H_END: begin
          if (tim_end) begin
            link.chip_select    <= 1'b0;
            link.serial_data_in <= 1'b0;
            rd_valid            <= rd_op_q;
            state_q             <= MDSP_H_GAP;
          end
        end
        MDSP_H_GAP: begin
          if (tim_end) begin
            state_q <= MDSP_H_IDLE;
          end
        end
        default: begin
          state_q <= MDSP_H_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: verilog/mdsp_if.sv */
// Four-wire serial link plus frame sync between host and motor driver
`default_nettype none
interface mdsp_if;
  logic chip_select;
  logic serial_clock;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic frame_sync_in;
  logic serial_data_out_line;

  // Undriven line reads low, as a pull-down would give
  assign serial_data_out_line = serial_data_out_oe & serial_data_out;

  modport dev (
    input  chip_select, serial_clock, serial_data_in, frame_sync_in,
    output serial_data_out, serial_data_out_oe
  );
  modport host (
    output chip_select, serial_clock, serial_data_in, frame_sync_in,
    input  serial_data_out_line
  );
endinterface
`default_nettype wire

/* File: verilog/mdsp_pkg.sv */
// Types shared by both ends of the motor driver serial port
`default_nettype none
package mdsp_pkg;
  typedef enum logic [2:0] {
    MDSP_H_IDLE,
    MDSP_H_SETUP,
    MDSP_H_LOW,
    MDSP_H_HIGH,
    MDSP_H_END,
    MDSP_H_GAP
  } mdsp_host_state_t;
endpackage
`default_nettype wire

/* File: verilog/mdsp_regs.svh */
// Register offsets, field positions and timing counts of the motor driver serial port
`ifndef MDSP_REGS_SVH
`define MDSP_REGS_SVH

`define MDSP_FRAME_BITS     5'd24
`define MDSP_LAST_BIT       5'd23
`define MDSP_CTRL_BIT       5'd7

`define MDSP_OFF_SYNC_TEST  6'h0b
`define MDSP_OFF_START_PWM  6'h20
`define MDSP_OFF_TEST_SEL   6'h21
`define MDSP_OFF_PHASE_DLY  6'h27
`define MDSP_OFF_PEAK_PW    6'h28
`define MDSP_OFF_STEP_CTRL  6'h29
`define MDSP_OFF_STEP_PER   6'h2a
`define MDSP_OFF_DC_CTRL    6'h2c

`define MDSP_MASK_SYNC_TEST 16'h0280
`define MDSP_MASK_START_PWM 16'h7fff
`define MDSP_MASK_TEST_SEL  16'h009f
`define MDSP_MASK_PHASE_DLY 16'h3fff
`define MDSP_MASK_PEAK_PW   16'hffff
`define MDSP_MASK_STEP_CTRL 16'h7cff
`define MDSP_MASK_STEP_PER  16'hffff
`define MDSP_MASK_DC_CTRL   16'h0007
`define MDSP_RESET_VALUE    16'h0000

`define MDSP_BIT_SYNC_EDGE  9
`define MDSP_BIT_TEST_A     7
`define MDSP_BIT_TEST_B     7
`define MDSP_BIT_DC_EN      2
`define MDSP_BIT_DC_A       1
`define MDSP_BIT_DC_B       0

`define MDSP_CLK_PERIOD_NS  100
`define MDSP_SCK_HALF_CYC   4'd8
`define MDSP_FS_WIDTH_NS    80000
`define MDSP_FS_WIDTH_CYC   ((`MDSP_FS_WIDTH_NS + `MDSP_CLK_PERIOD_NS - 1) / `MDSP_CLK_PERIOD_NS)
`define MDSP_CS_WAIT_NS     400
`define MDSP_CS_WAIT_CYC    ((`MDSP_CS_WAIT_NS + `MDSP_CLK_PERIOD_NS - 1) / `MDSP_CLK_PERIOD_NS)

`endif
